// ---- ebswc_pkg.sv ----
// Package for the external bus size / wait configuration block.
// Assumes a 32-bit APB master and an external bus sequencer that uses acc_cfg.
package ebswc_pkg;

  // ==========================================================================
  // Register byte offsets
  localparam logic [11:0] EBSWC_OFF_BUS_WIDTH = 12'h000;
  localparam logic [11:0] EBSWC_OFF_LONG_WAIT = 12'h004;
  localparam logic [11:0] EBSWC_OFF_IDLE_WAIT = 12'h008;
  localparam logic [11:0] EBSWC_OFF_EXT_CFG   = 12'h00C;

  // ==========================================================================
  // Reset values and writable masks
  localparam logic [15:0] EBSWC_RST_BUS_WIDTH  = 16'h00FC;
  localparam logic [15:0] EBSWC_RST_LONG_WAIT  = 16'h0F00;
  localparam logic [15:0] EBSWC_RST_IDLE_WAIT  = 16'hAAFF;
  localparam logic [31:0] EBSWC_RST_EXT_CFG    = 32'h0BFF0000;
  localparam logic [15:0] EBSWC_MASK_BUS_WIDTH = 16'h03FC;
  localparam logic [15:0] EBSWC_MASK_LONG_WAIT = 16'h0FC7;
  localparam logic [15:0] EBSWC_MASK_IDLE_WAIT = 16'hFFFF;
  localparam logic [31:0] EBSWC_MASK_EXT_CFG   = 32'h0FFF01FF;

  // ==========================================================================
  // Field positions
  localparam int EBSWC_POS_AREA4_WIDTH = 8;
  localparam int EBSWC_POS_AREA1_WIDTH = 2;
  localparam int EBSWC_POS_LW_HIGH     = 8;
  localparam int EBSWC_POS_AREA23_LW   = 10;
  localparam int EBSWC_POS_AREA4_LW    = 11;
  localparam int EBSWC_POS_DMA_WAIT    = 6;
  localparam int EBSWC_POS_BANK_SEL    = 2;
  localparam int EBSWC_POS_EDO         = 1;
  localparam int EBSWC_POS_BURST_WR    = 0;
  localparam int EBSWC_POS_IDLE_CODES  = 8;
  localparam int EBSWC_POS_MEM_TYPE    = 0;
  localparam int EBSWC_POS_SDRAM_64M   = 3;
  localparam int EBSWC_POS_WAIT_MASK   = 4;
  localparam int EBSWC_POS_LW_LOW      = 16;
  localparam int EBSWC_POS_AREA4_WAIT  = 24;
  localparam int EBSWC_POS_AREA4_IDLE  = 26;

  // ==========================================================================
  // Types
  typedef enum logic [1:0] {EBSWC_W8, EBSWC_W16, EBSWC_W32} ebswc_width_e;
  typedef enum logic [1:0] {EBSWC_ORD, EBSWC_DRAM, EBSWC_SDRAM} ebswc_mem_e;
  typedef enum logic [0:0] {EBSWC_S_IDLE, EBSWC_S_BUSY} ebswc_state_e;

  typedef struct packed {
    ebswc_width_e width;
    logic         width_valid;
    ebswc_mem_e   mem_type;
    logic [3:0]   wait_cycles;
    logic         ext_wait_en;
    logic [1:0]   cas_cycles;
    logic [2:0]   cas_latency;
    logic         edo_mode;
    logic         burst_write;
    logic         two_banks;
    logic [2:0]   idle_min;
  } ebswc_cfg_s;

endpackage

// ---- ebswc_seq_model.sv ----
// Stand-in for the external bus sequencer on the far side of the block.
// Assumes one core clock; the bench calls access() for one access at a time.
`timescale 1ns/1ps
module ebswc_seq_model (
  input  wire logic       core_clk,
  input  wire logic       acc_grant,
  output logic            acc_req,
  output logic [2:0]      acc_area,
  output logic            acc_write,
  output logic            acc_done
);
  initial begin
    acc_req   = 1'b0;
    acc_area  = 3'h0;
    acc_write = 1'b0;
    acc_done  = 1'b0;
  end

  // ==========================================================================
  // One access: request, hold until granted, then end it with a done pulse
  // Gap counts the cycles the request was held off before the grant
  task automatic access(input logic [2:0] area, input logic wr, output int gap);
    gap = 0;
    acc_req   <= 1'b1;
    acc_area  <= area;
    acc_write <= wr;
    @(negedge core_clk);
    while (acc_grant !== 1'b1) begin
      gap++;
      @(negedge core_clk);
    end
    @(posedge core_clk);
    acc_req <= 1'b0;
    // Done comes a cycle later so it never lands on the grant edge
    @(posedge core_clk);
    acc_done <= 1'b1;
    @(posedge core_clk);
    acc_done <= 1'b0;
  endtask
endmodule

// ---- ebswc_top.sv ----
// External bus size and wait configuration: APB register bank plus the
// per-access decode and the idle-gap gate in front of the bus sequencer.
// Assumes an outside sequencer requests accesses and reports their end.
//
// Local design decisions: the address map and register access over APB.
`timescale 1ns/1ps

module ebswc_top (
  input  wire logic                 core_clk,
  input  wire logic                 rst,
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [11:0]          paddr,
  input  wire logic [31:0]          pwdata,
  input  wire logic [3:0]           pstrb,
  output logic      [31:0]          prdata,
  output logic                      pready,
  output logic                      pslverr,
  input  wire logic                 boot_width_pin_hi,
  input  wire logic                 boot_width_pin_lo,
  input  wire logic                 acc_req,
  input  wire logic [2:0]           acc_area,
  input  wire logic                 acc_write,
  input  wire logic                 acc_done,
  output logic                      acc_grant,
  output ebswc_pkg::ebswc_cfg_s     acc_cfg,
  output logic      [1:0]           dma_single_write_wait
);
  import ebswc_pkg::*;

  // ==========================================================================
  // State
  typedef struct packed {
    logic [15:0]  area_bus_width_control;
    logic [15:0]  long_wait_dram_option_control;
    logic [15:0]  idle_and_wait_control_low_areas;
    logic [31:0]  ext_config;
    logic [31:0]  rdata;
    ebswc_state_e state;
    logic [2:0]   idle_left;
    logic [2:0]   prev_area;
    logic         prev_read;
    logic         prev_valid;
    logic         cur_read;
    ebswc_cfg_s   cfg;
  } ebswc_regs_s;

  ebswc_regs_s s_q;
  ebswc_regs_s s_d;

  // ==========================================================================
  // Decode helpers
  function automatic logic [3:0] ebswc_long_wait(input logic [2:0] code);
    logic [3:0] n;
    n = 4'h0;
    case (code)
      3'h0:    n = 4'h3;
      3'h1:    n = 4'h4;
      3'h2:    n = 4'h5;
      3'h3:    n = 4'h6;
      3'h4:    n = 4'h8;
      3'h5:    n = 4'hA;
      3'h6:    n = 4'hC;
      default: n = 4'hE;
    endcase
    return n;
  endfunction

  function automatic logic [2:0] ebswc_idle(input logic [1:0] code);
    logic [2:0] n;
    n = 3'h0;
    case (code)
      2'h0:    n = 3'h0;
      2'h1:    n = 3'h1;
      2'h2:    n = 3'h2;
      default: n = 3'h4;
    endcase
    return n;
  endfunction

  // Area 4 and boot pins share one coding; areas 1-3 treat 00 as reserved
  function automatic ebswc_width_e ebswc_width(input logic [1:0] code,
                                               input logic       zero_is_32);
    ebswc_width_e w;
    w = EBSWC_W32;
    case (code)
      2'h1:    w = EBSWC_W8;
      2'h2:    w = EBSWC_W16;
      2'h0:    w = zero_is_32 ? EBSWC_W32 : EBSWC_W8;
      default: w = EBSWC_W32;
    endcase
    return w;
  endfunction

  logic [2:0]   mem_type_code;
  ebswc_mem_e   area2_type;
  ebswc_mem_e   area3_type;
  ebswc_cfg_s   req_cfg;
  logic [1:0]   width_code;
  logic [1:0]   wait_code;
  logic [1:0]   idle_code;
  logic [1:0]   lw_low;
  logic         lw_high;
  logic         wait_mask;
  logic         gap_needed;
  logic         gap_ok;
  logic [31:0]  rd_mux;
  logic         addr_hit;
  logic         wr_fire;
  logic [31:0]  wmask;

  assign mem_type_code = s_q.ext_config[EBSWC_POS_MEM_TYPE +: 3];

  // Reserved area mode codes fall back to ordinary space
  always_comb begin
    area2_type = EBSWC_ORD;
    area3_type = EBSWC_ORD;
    case (mem_type_code)
      3'h1: begin
        area3_type = EBSWC_SDRAM;
      end
      3'h2: begin
        area3_type = EBSWC_DRAM;
      end
      3'h4: begin
        area2_type = EBSWC_SDRAM;
      end
      3'h5: begin
        area2_type = EBSWC_SDRAM;
        area3_type = EBSWC_SDRAM;
      end
      default: begin
        area2_type = EBSWC_ORD;
      end
    endcase
  end

  // ==========================================================================
  // Per-area field selection for the requested access
  always_comb begin
    width_code = 2'h0;
    wait_code  = s_q.ext_config[EBSWC_POS_AREA4_WAIT +: 2];
    idle_code  = s_q.ext_config[EBSWC_POS_AREA4_IDLE +: 2];
    lw_low     = s_q.ext_config[EBSWC_POS_LW_LOW + 6 +: 2];
    lw_high    = s_q.long_wait_dram_option_control[EBSWC_POS_AREA4_LW];
    wait_mask  = s_q.ext_config[EBSWC_POS_WAIT_MASK + 4];
    req_cfg    = '0;
    if (acc_area < 3'h4) begin
      wait_code = s_q.idle_and_wait_control_low_areas[2 * acc_area[1:0] +: 2];
      idle_code = s_q.idle_and_wait_control_low_areas[EBSWC_POS_IDLE_CODES
                                                      + 2 * acc_area[1:0] +: 2];
      wait_mask = s_q.ext_config[EBSWC_POS_WAIT_MASK + acc_area[1:0]];
      // Areas 2 and 3 share one long-wait group
      if (acc_area[1]) begin
        lw_low  = s_q.ext_config[EBSWC_POS_LW_LOW + 4 +: 2];
        lw_high = s_q.long_wait_dram_option_control[EBSWC_POS_AREA23_LW];
      end else begin
        lw_low  = s_q.ext_config[EBSWC_POS_LW_LOW + 2 * acc_area[1:0] +: 2];
        lw_high = s_q.long_wait_dram_option_control[EBSWC_POS_LW_HIGH
                                                    + acc_area[1:0]];
      end
    end
    case (acc_area)
      3'h0: begin
        req_cfg.width = ebswc_width({boot_width_pin_hi, boot_width_pin_lo},
                                    1'b1);
      end
      3'h1, 3'h2, 3'h3: begin
        width_code    = s_q.area_bus_width_control[EBSWC_POS_AREA1_WIDTH
                                                   + 2 * (acc_area[1:0] - 2'h1) +: 2];
        req_cfg.width = ebswc_width(width_code, 1'b0);
      end
      default: begin
        width_code    = s_q.area_bus_width_control[EBSWC_POS_AREA4_WIDTH +: 2];
        req_cfg.width = ebswc_width(width_code, 1'b1);
      end
    endcase
    req_cfg.mem_type = EBSWC_ORD;
    if (acc_area == 3'h2) begin
      req_cfg.mem_type = area2_type;
    end else if (acc_area == 3'h3) begin
      req_cfg.mem_type = area3_type;
    end
    req_cfg.width_valid = (req_cfg.mem_type == EBSWC_ORD);
    req_cfg.idle_min    = ebswc_idle(idle_code);
    case (req_cfg.mem_type)
      EBSWC_DRAM: begin
        // Reserved code 11 is clamped to the longest CAS length
        req_cfg.cas_cycles  = (wait_code == 2'h3) ? 2'h2 : wait_code;
        req_cfg.ext_wait_en = !wait_mask && (wait_code != 2'h0);
        req_cfg.edo_mode    = s_q.long_wait_dram_option_control[EBSWC_POS_EDO];
      end
      EBSWC_SDRAM: begin
        req_cfg.cas_latency = {1'b0, wait_code} + 3'h1;
        req_cfg.ext_wait_en = 1'b0;
        req_cfg.burst_write = s_q.long_wait_dram_option_control[EBSWC_POS_BURST_WR];
        req_cfg.two_banks   = s_q.ext_config[EBSWC_POS_SDRAM_64M]
                              && s_q.long_wait_dram_option_control[EBSWC_POS_BANK_SEL];
      end
      default: begin
        req_cfg.wait_cycles = (wait_code == 2'h3) ? ebswc_long_wait({lw_high, lw_low})
                                                  : {2'h0, wait_code};
        req_cfg.ext_wait_en = !wait_mask && (wait_code != 2'h0);
      end
    endcase
  end

  // ==========================================================================
  // Idle gap: the count loaded at the end of an access belongs to that
  // access's area, and it keeps running down while the bus sits idle, so
  // idle time already spent counts towards the gap.
  assign gap_needed = s_q.prev_valid
                      && ((acc_area != s_q.prev_area)
                          || (s_q.prev_read && acc_write));
  assign gap_ok     = !gap_needed || (s_q.idle_left == 3'h0);
  assign acc_grant  = (s_q.state == EBSWC_S_IDLE) && acc_req && gap_ok;

  // ==========================================================================
  // APB slave: read data is captured in the setup cycle, so pready is
  // always high and every transfer completes in two cycles.
  assign addr_hit = (paddr == EBSWC_OFF_BUS_WIDTH) || (paddr == EBSWC_OFF_LONG_WAIT)
                    || (paddr == EBSWC_OFF_IDLE_WAIT) || (paddr == EBSWC_OFF_EXT_CFG);
  assign wr_fire  = psel && penable && pwrite && addr_hit;

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_lane
      assign wmask[8 * gi +: 8] = {8{pstrb[gi]}};
    end
  endgenerate

  always_comb begin
    rd_mux = 32'h00000000;
    case (paddr)
      EBSWC_OFF_BUS_WIDTH: rd_mux = {16'h0000, s_q.area_bus_width_control};
      EBSWC_OFF_LONG_WAIT: rd_mux = {16'h0000, s_q.long_wait_dram_option_control};
      EBSWC_OFF_IDLE_WAIT: rd_mux = {16'h0000, s_q.idle_and_wait_control_low_areas};
      EBSWC_OFF_EXT_CFG:   rd_mux = s_q.ext_config;
      default:             rd_mux = 32'h00000000;
    endcase
  end

  assign prdata  = s_q.rdata;
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !addr_hit;
  assign acc_cfg = s_q.cfg;
  assign dma_single_write_wait =
    s_q.long_wait_dram_option_control[EBSWC_POS_DMA_WAIT +: 2];

  // ==========================================================================
  // Next state
  always_comb begin
    s_d = s_q;
    if (psel && !penable && !pwrite) begin
      s_d.rdata = rd_mux;
    end
    // Reserved bits are masked on write so they always read zero
    if (wr_fire) begin
      case (paddr)
        EBSWC_OFF_BUS_WIDTH: s_d.area_bus_width_control =
          (s_q.area_bus_width_control & ~(wmask[15:0] & EBSWC_MASK_BUS_WIDTH))
          | (pwdata[15:0] & wmask[15:0] & EBSWC_MASK_BUS_WIDTH);
        EBSWC_OFF_LONG_WAIT: s_d.long_wait_dram_option_control =
          (s_q.long_wait_dram_option_control & ~(wmask[15:0] & EBSWC_MASK_LONG_WAIT))
          | (pwdata[15:0] & wmask[15:0] & EBSWC_MASK_LONG_WAIT);
        EBSWC_OFF_IDLE_WAIT: s_d.idle_and_wait_control_low_areas =
          (s_q.idle_and_wait_control_low_areas & ~(wmask[15:0] & EBSWC_MASK_IDLE_WAIT))
          | (pwdata[15:0] & wmask[15:0] & EBSWC_MASK_IDLE_WAIT);
        default: s_d.ext_config =
          (s_q.ext_config & ~(wmask & EBSWC_MASK_EXT_CFG))
          | (pwdata & wmask & EBSWC_MASK_EXT_CFG);
      endcase
    end
    case (s_q.state)
      EBSWC_S_IDLE: begin
        if (s_q.idle_left != 3'h0) begin
          s_d.idle_left = s_q.idle_left - 3'h1;
        end
        if (acc_grant) begin
          s_d.cfg      = req_cfg;
          s_d.cur_read = !acc_write;
          s_d.prev_area = acc_area;
          s_d.state    = EBSWC_S_BUSY;
        end
      end
      EBSWC_S_BUSY: begin
        if (acc_done) begin
          s_d.state      = EBSWC_S_IDLE;
          s_d.prev_valid = 1'b1;
          s_d.prev_read  = s_q.cur_read;
          s_d.idle_left  = s_q.cfg.idle_min;
        end
      end
      default: begin
        s_d.state = EBSWC_S_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      s_q <= '0;
      s_q.area_bus_width_control          <= EBSWC_RST_BUS_WIDTH;
      s_q.long_wait_dram_option_control   <= EBSWC_RST_LONG_WAIT;
      s_q.idle_and_wait_control_low_areas <= EBSWC_RST_IDLE_WAIT;
      s_q.ext_config                      <= EBSWC_RST_EXT_CFG;
      s_q.state                           <= EBSWC_S_IDLE;
    end else begin
      s_q <= s_d;
    end
  end

  // ==========================================================================
  // Checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  a_gap_before_grant: assert property (s_q.state == EBSWC_S_BUSY && acc_done
      && s_q.cfg.idle_min != 3'h0 |=> !acc_grant
      || (acc_area == s_q.prev_area && !(s_q.prev_read && acc_write)))
    else $error("access granted before idle gap elapsed");
  a_rd_wr_idle: assert property (s_q.state == EBSWC_S_IDLE && s_q.prev_valid && s_q.prev_read
      && acc_req && acc_write && s_q.idle_left != 3'h0 |-> !acc_grant)
    else $error("write after read granted without idle");
  a_idle_load: assert property (s_q.state == EBSWC_S_BUSY && acc_done
      |=> s_q.idle_left == $past(s_q.cfg.idle_min))
    else $error("idle count not taken from previous area");
  a_cfg_stable: assert property (s_q.state == EBSWC_S_BUSY && !acc_done ##1 1
      |-> $stable(acc_cfg))
    else $error("access config changed mid access");
  a_long_wait_range: assert property (acc_grant && req_cfg.mem_type == EBSWC_ORD
      && wait_code == 2'h3 |=> acc_cfg.wait_cycles >= 4'h3 && acc_cfg.wait_cycles <= 4'hE)
    else $error("long wait outside 3 to 14");
  a_sdram_no_wait: assert property (acc_cfg.mem_type == EBSWC_SDRAM |-> !acc_cfg.ext_wait_en)
    else $error("external wait enabled for SDRAM");
  a_dram_wait_gate: assert property (acc_cfg.mem_type == EBSWC_DRAM
      && (acc_cfg.cas_cycles == 2'h0 || s_q.ext_config[EBSWC_POS_WAIT_MASK + 3] && $stable(s_q.ext_config))
      && s_q.state == EBSWC_S_BUSY && $past(s_q.state) == EBSWC_S_IDLE
      |-> !acc_cfg.ext_wait_en)
    else $error("DRAM external wait wrongly enabled");
  a_area0_pins: assert property (acc_grant && acc_area == 3'h0
      && {boot_width_pin_hi, boot_width_pin_lo} == 2'h1 |=> acc_cfg.width == EBSWC_W8)
    else $error("area 0 width not from pins");
  a_area4_zero: assert property (acc_grant && acc_area == 3'h4
      && s_q.area_bus_width_control[EBSWC_POS_AREA4_WIDTH +: 2] == 2'h0
      |=> acc_cfg.width == EBSWC_W32)
    else $error("area 4 code 00 not 32-bit");
  a_reserved_zero: assert property (psel && penable && !pwrite
      && paddr == EBSWC_OFF_LONG_WAIT |-> (prdata[31:0] & ~{16'h0000, EBSWC_MASK_LONG_WAIT}) == '0)
    else $error("reserved bits read nonzero");

endmodule

// ---- tb_external_bus_size_wait_config.sv ----
// Self-checking bench for the bus size and wait configuration block.
// Assumes the sequencer model answers the access port; APB driven here.
`timescale 1ns/1ps
`define EB_CHK(nm, exp, act) begin checked++; if ((act) !== (exp)) begin num_errors++; \
  $display("ERROR %s expected %0h seen %0h", nm, exp, act); end end
module tb_external_bus_size_wait_config;
  import ebswc_pkg::*;
  logic core_clk, rst, psel, penable, pwrite, pready, pslverr, pin_hi, pin_lo;
  logic acc_req, acc_write, acc_done, acc_grant;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [2:0]  acc_area;
  logic [1:0]  dma_wait;
  ebswc_cfg_s  cfg;
  int          num_errors = 0;
  int          checked = 0;
  localparam logic [11:0] OFFS [4] = '{12'h000, 12'h004, 12'h008, 12'h00C};
  localparam logic [31:0] RSTS [4] = '{32'h00FC, 32'h0F00, 32'hAAFF, 32'h0BFF0000};
  localparam logic [31:0] MSKS [4] = '{32'h03FC, 32'h0FC7, 32'hFFFF, 32'h0FFF01FF};
  localparam ebswc_width_e W4 [4] = '{EBSWC_W32, EBSWC_W8, EBSWC_W16, EBSWC_W32};
  localparam logic [3:0] LW [8] = '{4'h3, 4'h4, 4'h5, 4'h6, 4'h8, 4'hA, 4'hC, 4'hE};

  initial begin
    core_clk = 1'b0;
    rst = 1'b1;
    {psel, penable, pwrite, pin_hi, pin_lo} = '0;
    paddr = '0;
    pwdata = '0;
  end
  always #25 core_clk = ~core_clk;

  ebswc_top dut (.core_clk(core_clk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hF), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .boot_width_pin_hi(pin_hi),
    .boot_width_pin_lo(pin_lo), .acc_req(acc_req), .acc_area(acc_area),
    .acc_write(acc_write), .acc_done(acc_done), .acc_grant(acc_grant),
    .acc_cfg(cfg), .dma_single_write_wait(dma_wait));
  ebswc_seq_model seq (.core_clk(core_clk), .acc_grant(acc_grant), .acc_req(acc_req),
    .acc_area(acc_area), .acc_write(acc_write), .acc_done(acc_done));

  // ==========================================================================
  // Bus tasks
  task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    @(posedge core_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    do begin
      @(posedge core_clk);
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(a, 1'b1, d, r, e);
  endtask
  task automatic chk_rd(input string nm, input logic [11:0] a, input logic [31:0] x);
    logic [31:0] r;
    logic e;
    apb(a, 1'b0, 32'h0, r, e);
    `EB_CHK(nm, x, r)
  endtask
  task automatic acc(input logic [2:0] ar, input logic w);
    int g;
    seq.access(ar, w, g);
  endtask
  // Mid-run reset so a scenario starts from the register reset values
  task automatic do_reset();
    rst <= 1'b1;
    repeat (8) @(posedge core_clk);
    rst <= 1'b0;
  endtask

  // ==========================================================================
  // Scenarios
  task automatic t_regs();
    logic [31:0] r;
    logic e;
    for (int i = 0; i < 4; i++) begin
      chk_rd("reg_reset", OFFS[i], RSTS[i]);
      wr(OFFS[i], 32'hFFFF_FFFF);
      chk_rd("reg_reserved", OFFS[i], MSKS[i]);
      wr(OFFS[i], RSTS[i]);
    end
    apb(12'h010, 1'b0, 32'h0, r, e);
    `EB_CHK("unmapped_err", 1'b1, e);
    $display("test regs done");
  endtask
  task automatic t_width();
    for (int c = 0; c < 4; c++) begin
      wr(12'h000, 32'h00FC | (32'(c) << 8));
      acc(3'd4, 1'b0);
      `EB_CHK("area4_width", W4[c], cfg.width);
      pin_hi <= c[1];
      pin_lo <= c[0];
      acc(3'd0, 1'b0);
      `EB_CHK("area0_width", W4[c], cfg.width);
    end
    for (int c = 1; c < 4; c++) begin
      wr(12'h000, 32'h0030 | (32'(c) << 6) | (32'(c) << 2));
      acc(3'd1, 1'b0);
      `EB_CHK("area1_width", W4[c], cfg.width);
      acc(3'd3, 1'b0);
      `EB_CHK("area3_width", W4[c], cfg.width);
    end
    wr(12'h000, 32'h00FC);
    $display("test width done");
  endtask
  task automatic t_wait();
    for (int c = 0; c < 4; c++) begin
      wr(12'h008, 32'hAAF3 | (32'(c) << 2));
      acc(3'd1, 1'b0);
      `EB_CHK("ext_wait_en", (c != 0), cfg.ext_wait_en);
      if (c < 3) `EB_CHK("short_wait", 4'(c), cfg.wait_cycles);
      if (c < 3) wr(12'h004, 32'h0F00 | (32'(c) << 6));
      @(negedge core_clk);
      if (c < 3) `EB_CHK("dma_wait", 2'(c), dma_wait);
    end
    for (int l = 0; l < 8; l++) begin
      wr(12'h004, 32'h0D00 | (32'(l >> 2) << 9));
      wr(12'h00C, 32'h0BF30000 | (32'(l & 3) << 18));
      acc(3'd1, 1'b0);
      `EB_CHK("long_wait", LW[l], cfg.wait_cycles);
    end
    wr(12'h004, 32'h0F00);
    wr(12'h00C, 32'h0BFF0000);
    $display("test wait done");
  endtask
  task automatic t_dram();
    do_reset();
    wr(12'h00C, 32'h0BFF0002);
    wr(12'h004, 32'h0F02);
    for (int c = 0; c < 3; c++) begin
      wr(12'h008, 32'hAA3F | (32'(c) << 6));
      acc(3'd3, 1'b0);
      `EB_CHK("dram_type", EBSWC_DRAM, cfg.mem_type);
      `EB_CHK("dram_width_off", 1'b0, cfg.width_valid);
      `EB_CHK("cas_cycles", 2'(c), cfg.cas_cycles);
      `EB_CHK("dram_ext_wait", (c != 0), cfg.ext_wait_en);
      `EB_CHK("edo_mode", 1'b1, cfg.edo_mode);
    end
    wr(12'h00C, 32'h0BFF0082);
    wr(12'h008, 32'hAA7F);
    acc(3'd3, 1'b0);
    `EB_CHK("dram_wait_mask", 1'b0, cfg.ext_wait_en);
    acc(3'd2, 1'b0);
    `EB_CHK("area2_width_on", 1'b1, cfg.width_valid);
    $display("test dram done");
  endtask
  task automatic t_sdram();
    logic [2:0] md [5] = '{3'd0, 3'd1, 3'd2, 3'd4, 3'd5};
    ebswc_mem_e m2 [5] = '{EBSWC_ORD, EBSWC_ORD, EBSWC_ORD, EBSWC_SDRAM, EBSWC_SDRAM};
    ebswc_mem_e m3 [5] = '{EBSWC_ORD, EBSWC_SDRAM, EBSWC_DRAM, EBSWC_ORD, EBSWC_SDRAM};
    do_reset();
    chk_rd("reset_again", 12'h004, 32'h0F00);
    for (int i = 0; i < 5; i++) begin
      wr(12'h00C, 32'h0BFF0000 | 32'(md[i]));
      acc(3'd2, 1'b0);
      `EB_CHK("area2_type", m2[i], cfg.mem_type);
      acc(3'd3, 1'b0);
      `EB_CHK("area3_type", m3[i], cfg.mem_type);
    end
    wr(12'h00C, 32'h0BFF000D);
    wr(12'h004, 32'h0F05);
    for (int c = 0; c < 4; c++) begin
      wr(12'h008, 32'hAACF | (32'(c) << 4));
      acc(3'd2, 1'b1);
      `EB_CHK("cas_latency", 3'(c + 1), cfg.cas_latency);
      `EB_CHK("sdram_no_ext_wait", 1'b0, cfg.ext_wait_en);
      `EB_CHK("burst_write", 1'b1, cfg.burst_write);
      `EB_CHK("two_banks", 1'b1, cfg.two_banks);
    end
    wr(12'h00C, 32'h0BFF0000);
    $display("test sdram done");
  endtask
  task automatic t_idle();
    int g;
    logic [2:0] ia [7] = '{3'd1, 3'd2, 3'd2, 3'd2, 3'd3, 3'd0, 3'd3};
    logic       iw [7] = '{1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0};
    int         ig [7] = '{-1, 4, 0, 1, 1, 2, 0};
    // Area codes: 3 two, 2 one, 1 four, 0 none
    wr(12'h008, 32'h9CFF);
    for (int i = 0; i < 7; i++) begin
      seq.access(ia[i], iw[i], g);
      if (i > 0) `EB_CHK("idle_gap", ig[i], g);
    end
    wr(12'h008, 32'hAAFF);
    $display("test idle done");
  endtask

  task automatic print_verdict();
    $display("checks %0d errors %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  initial begin
    repeat (8) @(posedge core_clk);
    rst <= 1'b0;
    t_regs();
    t_width();
    t_wait();
    t_dram();
    t_sdram();
    t_idle();
    print_verdict();
  end
  // Whole run needs a few hundred cycles; this is far past that
  initial begin
    repeat (20000) @(posedge core_clk);
    num_errors++;
    print_verdict();
  end
endmodule
